// >>> common/wdt_pkg.sv
// Package: watchdog / interval timer register map, fields, widths and types
package wdt_pkg;
  // -----------------------------------------------------------------
  // Register map (printed offsets are indexes; byte address = 4 * index)
  // -----------------------------------------------------------------
  localparam logic [15:0] CLOCK_SELECT_INDEX = 16'hFF42;
  localparam logic [15:0] MODE_CONTROL_INDEX = 16'hFF4B;
  localparam logic [31:0] CLOCK_SELECT_ADDR = {14'h0000, CLOCK_SELECT_INDEX, 2'h0};
  localparam logic [31:0] MODE_CONTROL_ADDR = {14'h0000, MODE_CONTROL_INDEX, 2'h0};
  // -----------------------------------------------------------------
  // Field positions and reset values
  // -----------------------------------------------------------------
  localparam int unsigned RESTART_BIT = 7;
  localparam int unsigned MODE_HIGH_BIT = 4;
  localparam int unsigned MODE_LOW_BIT = 3;
  localparam int unsigned CLOCK_SELECT_HIGH_BIT = 2;
  localparam int unsigned CLOCK_SELECT_LOW_BIT = 1;
  localparam logic [7:0] CLOCK_SELECT_RESET = 8'h00;
  localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
  // -----------------------------------------------------------------
  // Prescaler taps and counter width
  // -----------------------------------------------------------------
  localparam int unsigned MAIN_PRESCALE_W = 14;
  localparam int unsigned SUB_PRESCALE_W = 7;
  localparam int unsigned MAIN_TAP_SHORT = 13;
  localparam int unsigned MAIN_TAP_LONG = 14;
  localparam int unsigned SUB_TAP_SHORT = 6;
  localparam int unsigned SUB_TAP_LONG = 7;
  localparam int unsigned COUNT_W = 7;
  // -----------------------------------------------------------------
  // AHB-Lite codes
  // -----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  // -----------------------------------------------------------------
  // Types
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_STOPPED = 2'b00,
    MODE_INTERVAL = 2'b01,
    MODE_WATCHDOG_NMI = 2'b10,
    MODE_WATCHDOG_RESET = 2'b11
  } wdt_mode_t;
  typedef enum logic [1:0] {
    SEL_MAIN_SHORT = 2'b00,
    SEL_MAIN_LONG = 2'b01,
    SEL_SUB_SHORT = 2'b10,
    SEL_SUB_LONG = 2'b11
  } count_sel_t;
  typedef struct packed {
    logic restart;
    wdt_mode_t mode;
    count_sel_t sel;
  } wdt_ctrl_t;
endpackage

// >>> src/loop_detect_watchdog.sv
// Loop-detect watchdog / interval timer with AHB-Lite register slave
// Function
// [RULE_01] Clock-select field picks main/2^13, main/2^14, sub/2^6 or sub/2^7.
// [RULE_02] Overflow period is 2^20, 2^21 main or 2^13, 2^14 sub periods.
// [RULE_03] Writing one to restart bit clears counter and starts counting.
// [RULE_04] Restart bit is set-only; only system reset stops counting.
// [RULE_05] Mode bits select stopped, interval, watchdog NMI, watchdog reset.
// [RULE_06] Mode bits are set-only; watchdog mode blocks interval until reset.
// [RULE_07] Software restarts before each period expires, else NMI or reset.
// [RULE_08] Restart does not clear prescaler; first period may be 0.8% short.
// [RULE_09] Watchdog mode written while request flag set gives immediate NMI.
// [RULE_10] Interval mode raises its interrupt once every selected period.
// [RULE_11] Interval interrupt is gated by the mask; highest maskable priority.
// [RULE_12] Counting continues in halt and freezes in stop standby.
// [RULE_13] Software restarts the count just before executing stop.
// [RULE_14] Counting stops while the processor runs from the subsystem clock.
// [RULE_15] Clock-select takes full-byte writes; mode register bit or byte.
// [RULE_16] System reset clears both registers to all zeros.
// [RULE_17] Free-running prescaler feeds a counter overflowing after 128 ticks.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module loop_detect_watchdog (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic main_tick_in,
  input wire logic sub_tick_in,
  input wire logic stop_mode_in,
  input wire logic cpu_on_subclock_in,
  input wire logic watchdog_request_flag_in,
  input wire logic interval_interrupt_mask_in,
  output logic interval_interrupt_request_out,
  output logic nmi_request_out,
  output logic reset_request_out
);
  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic low_bits_full(input logic [13:0] v, input int unsigned n);
    logic full;
    full = 1'b1;
    for (int i = 0; i < 14; i++) begin
      if (i < n && !v[i]) begin
        full = 1'b0;
      end
    end
    return full;
  endfunction

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    return {24'h000000, b};
  endfunction

  // -----------------------------------------------------------------
  // AHB-Lite slave
  // -----------------------------------------------------------------
  logic dp_valid_reg;
  logic dp_write_reg;
  logic [31:0] dp_addr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  wdt_pkg::wdt_ctrl_t ctrl_reg;
  wdt_pkg::wdt_ctrl_t ctrl_next;

  wire addr_phase = hsel_in && hready_in && (htrans_in == wdt_pkg::HTRANS_NONSEQ);
  wire wr_clock_select = dp_valid_reg && dp_write_reg &&
                         (dp_addr_reg == wdt_pkg::CLOCK_SELECT_ADDR);
  wire wr_mode_control = dp_valid_reg && dp_write_reg &&
                         (dp_addr_reg == wdt_pkg::MODE_CONTROL_ADDR);
  wire [7:0] wbyte = hwdata_in[7:0];
  wire restart_wr = wr_mode_control && wbyte[wdt_pkg::RESTART_BIT];

  // Set-only bits: a zero write never clears them
  assign ctrl_next.restart = ctrl_reg.restart | restart_wr; // [RULE_04]
  assign ctrl_next.mode = wr_mode_control ?
      wdt_pkg::wdt_mode_t'(ctrl_reg.mode |
      {wbyte[wdt_pkg::MODE_HIGH_BIT], wbyte[wdt_pkg::MODE_LOW_BIT]}) : ctrl_reg.mode; // [RULE_06]
  assign ctrl_next.sel = wr_clock_select ?
      wdt_pkg::count_sel_t'({wbyte[wdt_pkg::CLOCK_SELECT_HIGH_BIT],
      wbyte[wdt_pkg::CLOCK_SELECT_LOW_BIT]}) : ctrl_reg.sel; // [RULE_01]

  wire [7:0] clock_select_view = {5'h00, ctrl_next.sel, 1'b0};
  wire [7:0] mode_control_view = {ctrl_next.restart, 2'h0, ctrl_next.mode, 3'h0};
  // Read data built from next-state values so a write just before is seen
  wire [31:0] rdata_next =
      (!addr_phase || hwrite_in) ? 32'h00000000 :
      (haddr_in == wdt_pkg::CLOCK_SELECT_ADDR) ? byte_word(clock_select_view) :
      (haddr_in == wdt_pkg::MODE_CONTROL_ADDR) ? byte_word(mode_control_view) :
      32'h00000000;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 32'h00000000;
      hrdata_reg <= 32'h00000000;
      hreadyout_reg <= 1'b1;
    end else begin
      dp_valid_reg <= addr_phase;
      dp_write_reg <= hwrite_in;
      dp_addr_reg <= haddr_in;
      hrdata_reg <= rdata_next;
      hreadyout_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ctrl_reg <= {wdt_pkg::MODE_CONTROL_RESET[wdt_pkg::RESTART_BIT], 2'b00,
                   wdt_pkg::CLOCK_SELECT_RESET[2:1]}; // [RULE_16]
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // -----------------------------------------------------------------
  // Prescaler and counter
  // -----------------------------------------------------------------
  logic [wdt_pkg::MAIN_PRESCALE_W-1:0] main_pres_reg;
  logic [wdt_pkg::SUB_PRESCALE_W-1:0] sub_pres_reg;
  logic [wdt_pkg::COUNT_W-1:0] count_reg;
  logic interval_irq_reg;
  logic nmi_reg;
  logic reset_req_reg;

  // Halt is not an input: the timer simply keeps counting through it
  wire freeze = stop_mode_in || cpu_on_subclock_in; // [RULE_12] [RULE_14]
  wire main_adv = main_tick_in && !freeze;
  wire sub_adv = sub_tick_in && !freeze;
  wire [13:0] sub_pres_wide = {7'h00, sub_pres_reg};
  wire main_short_tap = main_adv && low_bits_full(main_pres_reg, wdt_pkg::MAIN_TAP_SHORT);
  wire main_long_tap = main_adv && low_bits_full(main_pres_reg, wdt_pkg::MAIN_TAP_LONG);
  wire sub_short_tap = sub_adv && low_bits_full(sub_pres_wide, wdt_pkg::SUB_TAP_SHORT);
  wire sub_long_tap = sub_adv && low_bits_full(sub_pres_wide, wdt_pkg::SUB_TAP_LONG);
  logic sel_tap;
  always_comb begin
    case (ctrl_reg.sel)
      wdt_pkg::SEL_MAIN_SHORT: sel_tap = main_short_tap; // [RULE_01]
      wdt_pkg::SEL_MAIN_LONG: sel_tap = main_long_tap;
      wdt_pkg::SEL_SUB_SHORT: sel_tap = sub_short_tap;
      wdt_pkg::SEL_SUB_LONG: sel_tap = sub_long_tap;
      default: sel_tap = 1'b0;
    endcase
  end
  wire running = ctrl_reg.restart && (ctrl_reg.mode != wdt_pkg::MODE_STOPPED); // [RULE_05]
  wire count_tick = running && sel_tap;
  wire overflow = count_tick && (&count_reg) && !restart_wr; // [RULE_02] [RULE_17]
  // Watchdog mode entered while the request flag is still up
  wire early_nmi = wr_mode_control && wbyte[wdt_pkg::MODE_HIGH_BIT] &&
                   watchdog_request_flag_in; // [RULE_09]

  // Prescaler never cleared by restart; hence the short first period
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      main_pres_reg <= '0;
      sub_pres_reg <= '0;
    end else begin
      main_pres_reg <= main_pres_reg + {13'h0000, main_adv}; // [RULE_08]
      sub_pres_reg <= sub_pres_reg + {6'h00, sub_adv};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      count_reg <= '0;
    end else if (restart_wr) begin
      count_reg <= '0; // [RULE_03]
    end else if (count_tick) begin
      count_reg <= count_reg + 7'h01; // [RULE_17]
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      interval_irq_reg <= 1'b0;
      nmi_reg <= 1'b0;
      reset_req_reg <= 1'b0;
    end else begin
      interval_irq_reg <= overflow && (ctrl_reg.mode == wdt_pkg::MODE_INTERVAL) &&
                          !interval_interrupt_mask_in; // [RULE_10] [RULE_11]
      nmi_reg <= (overflow && (ctrl_reg.mode == wdt_pkg::MODE_WATCHDOG_NMI)) ||
                 early_nmi; // [RULE_05] [RULE_07]
      reset_req_reg <= overflow && (ctrl_reg.mode == wdt_pkg::MODE_WATCHDOG_RESET);
    end
  end

  assign hrdata_out = hrdata_reg;
  assign hreadyout_out = hreadyout_reg;
  assign hresp_out = wdt_pkg::HRESP_OKAY;
  assign interval_interrupt_request_out = interval_irq_reg;
  assign nmi_request_out = nmi_reg;
  assign reset_request_out = reset_req_reg;

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  property p_main_short_tap;
    @(posedge sys_clk_in) disable iff (srst_in)
    count_tick && (ctrl_reg.sel == wdt_pkg::SEL_MAIN_SHORT) |->
      (main_pres_reg[12:0] == 13'h1FFF) && main_tick_in;
  endproperty
  a_main_short_tap: assert property (p_main_short_tap) // [RULE_01]
    else $error("bad main/2^13 tap");

  property p_overflow_wraps;
    @(posedge sys_clk_in) disable iff (srst_in)
    overflow |-> (count_reg == 7'h7F) ##1 (count_reg == 7'h00);
  endproperty
  a_overflow_wraps: assert property (p_overflow_wraps) // [RULE_02]
    else $error("overflow not at 128");

  property p_restart_clears;
    @(posedge sys_clk_in) disable iff (srst_in)
    restart_wr |=> (count_reg == 7'h00) && ctrl_reg.restart && !interval_interrupt_request_out;
  endproperty
  a_restart_clears: assert property (p_restart_clears) // [RULE_03]
    else $error("restart did not clear");

  property p_restart_sticky;
    @(posedge sys_clk_in) disable iff (srst_in)
    ctrl_reg.restart |=> ctrl_reg.restart [*3];
  endproperty
  a_restart_sticky: assert property (p_restart_sticky) // [RULE_04]
    else $error("restart bit cleared");

  property p_mode_sticky;
    @(posedge sys_clk_in) disable iff (srst_in)
    (ctrl_reg.mode != wdt_pkg::MODE_STOPPED) |=> ((ctrl_reg.mode & $past(ctrl_reg.mode))
      == $past(ctrl_reg.mode));
  endproperty
  a_mode_sticky: assert property (p_mode_sticky) // [RULE_06]
    else $error("mode bit cleared");

  property p_wd_reset;
    @(posedge sys_clk_in) disable iff (srst_in)
    overflow && (ctrl_reg.mode == wdt_pkg::MODE_WATCHDOG_RESET) |=>
      reset_request_out && !interval_interrupt_request_out ##1 !reset_request_out;
  endproperty
  a_wd_reset: assert property (p_wd_reset) // [RULE_05]
    else $error("missing reset request");

  property p_early_nmi;
    @(posedge sys_clk_in) disable iff (srst_in)
    wr_mode_control && hwdata_in[4] && watchdog_request_flag_in |=> nmi_request_out;
  endproperty
  a_early_nmi: assert property (p_early_nmi) // [RULE_09]
    else $error("no NMI on flagged mode write");

  property p_interval_repeat;
    @(posedge sys_clk_in) disable iff (srst_in)
    overflow && (ctrl_reg.mode == wdt_pkg::MODE_INTERVAL) && !interval_interrupt_mask_in
      |=> interval_interrupt_request_out;
  endproperty
  a_interval_repeat: assert property (p_interval_repeat) // [RULE_10]
    else $error("interval irq lost");

  property p_mask_gates;
    @(posedge sys_clk_in) disable iff (srst_in)
    interval_interrupt_request_out |-> !$past(interval_interrupt_mask_in) && $past(overflow);
  endproperty
  a_mask_gates: assert property (p_mask_gates) // [RULE_11]
    else $error("masked irq escaped");

  property p_stop_freezes;
    @(posedge sys_clk_in) disable iff (srst_in)
    stop_mode_in && !restart_wr |=> $stable(count_reg) && $stable(main_pres_reg);
  endproperty
  a_stop_freezes: assert property (p_stop_freezes) // [RULE_12]
    else $error("count moved in stop");

  property p_subclock_stops;
    @(posedge sys_clk_in) disable iff (srst_in)
    cpu_on_subclock_in |-> !count_tick && !overflow;
  endproperty
  a_subclock_stops: assert property (p_subclock_stops) // [RULE_14]
    else $error("count on subclock cpu");

  property p_prescaler_kept;
    @(posedge sys_clk_in) disable iff (srst_in)
    restart_wr && !main_adv |=> $stable(main_pres_reg);
  endproperty
  a_prescaler_kept: assert property (p_prescaler_kept) // [RULE_08]
    else $error("prescaler touched");

  property p_reset_clears;
    @(posedge sys_clk_in) srst_in |=> (ctrl_reg == '0) && (count_reg == '0);
  endproperty
  a_reset_clears: assert property (p_reset_clears) // [RULE_16]
    else $error("registers not cleared");

  c_interval: cover property (@(posedge sys_clk_in) disable iff (srst_in)
    interval_interrupt_request_out);
  c_nmi: cover property (@(posedge sys_clk_in) disable iff (srst_in) nmi_request_out);
  c_reset: cover property (@(posedge sys_clk_in) disable iff (srst_in) reset_request_out);
  c_restart: cover property (@(posedge sys_clk_in) disable iff (srst_in)
    restart_wr && (count_reg != 7'h00));
endmodule // loop_detect_watchdog

// >>> tb/loop_detect_watchdog_test.sv
// Self-checking bench for the loop-detect watchdog / interval timer
`timescale 1ns/100ps
module loop_detect_watchdog_test;
  // ------------------------------------------------------------
  // Stimulus, wires and bookkeeping
  // ------------------------------------------------------------
  localparam int SUB_P = 8192;
  localparam int SUB_L = 16384;
  localparam int TAP = 64;
  logic clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, main_tick = 1'b0, sub_tick = 1'b1;
  logic stop_mode = 1'b0, cpu_sub = 1'b0, req_flag = 1'b0, irq_mask = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, irq, nmi, rst_req;
  int bad_count = 0, checks_done = 0, n_irq = 0, n_nmi = 0, n_rst = 0;

  loop_detect_watchdog loop_detect_watchdog_inst (
    .sys_clk_in(clk), .srst_in(srst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .main_tick_in(main_tick), .sub_tick_in(sub_tick), .stop_mode_in(stop_mode),
    .cpu_on_subclock_in(cpu_sub), .watchdog_request_flag_in(req_flag),
    .interval_interrupt_mask_in(irq_mask), .interval_interrupt_request_out(irq),
    .nmi_request_out(nmi), .reset_request_out(rst_req));

  initial begin
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (irq === 1'b1) n_irq++;
    if (nmi === 1'b1) n_nmi++;
    if (rst_req === 1'b1) n_rst++;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check_win(input int n, input int lo, input int hi, input string what);
    checks_done++;
    if (n < lo || n > hi) begin
      bad_count++;
      $display("unexpected at %0t: %s after %0d cycles, window %0d..%0d", $time, what, n, lo, hi);
    end
  endtask

  // Holds each phase until hready is sampled high; read data taken at the last edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= wdt_pkg::HTRANS_NONSEQ;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    xfer(1'b1, a, d, rd);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    xfer(1'b0, a, 32'h0, rd);
    check_val(rd, exp, what);
    check_val({31'h0, hresp}, {31'h0, wdt_pkg::HRESP_OKAY}, "response code");
  endtask

  // Counts edges until the chosen request pulse is seen: 0 interval, 1 nmi, 2 reset
  task automatic await(input int which, input int lo, input int hi, input string what);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n <= hi) begin
      @(posedge clk);
      n++;
      hit = ((which == 0) ? irq : (which == 1) ? nmi : rst_req) === 1'b1;
    end
    check_win(n, lo, hi, what);
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    req_flag <= 1'b0;
    irq_mask <= 1'b0;
    repeat (16) @(posedge clk);
    // Outputs are quiet in reset, so the tallies can restart here
    n_irq = 0;
    n_nmi = 0;
    n_rst = 0;
    srst <= 1'b0;
    @(posedge clk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_values();
    do_reset();
    rd_chk(wdt_pkg::CLOCK_SELECT_ADDR, 32'h0, "clock select reset");
    rd_chk(wdt_pkg::MODE_CONTROL_ADDR, 32'h0, "mode reset");
    rd_chk(32'h0000_0100, 32'h0, "unmapped read");
  endtask

  task automatic t_interval();
    int k;
    do_reset();
    wr(wdt_pkg::CLOCK_SELECT_ADDR, 32'h0000_0004);
    rd_chk(wdt_pkg::CLOCK_SELECT_ADDR, 32'h0000_0004, "clock select");
    wr(wdt_pkg::MODE_CONTROL_ADDR, 32'h0000_0088);
    await(0, SUB_P - TAP - 2, SUB_P + 4, "first interval");
    await(0, SUB_P, SUB_P, "second interval");
    irq_mask <= 1'b1;
    // Let the tally of the pulse just seen settle first
    @(posedge clk);
    k = n_irq;
    repeat (SUB_P + 8) @(posedge clk);
    check_val(32'(n_irq), 32'(k), "masked interval");
    irq_mask <= 1'b0;
    wr(wdt_pkg::MODE_CONTROL_ADDR, 32'h0000_0008);
    rd_chk(wdt_pkg::MODE_CONTROL_ADDR, 32'h0000_0088, "restart sticky");
    check_val(32'(n_nmi + n_rst), 32'h0, "interval raises no nmi");
  endtask

  // Main ticks reach one count tick only; sub ticks must be ignored
  task automatic t_main_select();
    int k;
    main_tick <= 1'b1;
    do_reset();
    wr(wdt_pkg::MODE_CONTROL_ADDR, 32'h0000_0088);
    k = n_irq;
    repeat (SUB_P + 8) @(posedge clk);
    check_val(32'(n_irq), 32'(k), "main select counts sub ticks");
    main_tick <= 1'b0;
  endtask

  task automatic t_nmi();
    int k;
    do_reset();
    wr(wdt_pkg::CLOCK_SELECT_ADDR, 32'h0000_0004);
    req_flag <= 1'b1;
    wr(wdt_pkg::MODE_CONTROL_ADDR, 32'h0000_0090);
    await(1, 1, 3, "early nmi");
    req_flag <= 1'b0;
    @(posedge clk);
    k = n_nmi;
    repeat (2) begin
      repeat (6000) @(posedge clk);
      wr(wdt_pkg::MODE_CONTROL_ADDR, 32'h0000_0080);
    end
    check_val(32'(n_nmi), 32'(k), "serviced watchdog fired");
    rd_chk(wdt_pkg::MODE_CONTROL_ADDR, 32'h0000_0090, "mode after restarts");
    wr(wdt_pkg::MODE_CONTROL_ADDR, 32'h0000_0080);
    stop_mode <= 1'b1;
    repeat (2000) @(posedge clk);
    stop_mode <= 1'b0;
    cpu_sub <= 1'b1;
    repeat (2000) @(posedge clk);
    cpu_sub <= 1'b0;
    check_val(32'(n_nmi), 32'(k), "frozen watchdog fired");
    await(1, SUB_P - 2 * TAP - 200, SUB_P + 4, "nmi on expiry");
    check_val(32'(n_rst + n_irq), 32'h0, "nmi mode raised others");
  endtask

  task automatic t_reset_mode();
    do_reset();
    wr(wdt_pkg::MODE_CONTROL_ADDR, 32'h0000_0008);
    wr(wdt_pkg::MODE_CONTROL_ADDR, 32'h0000_0010);
    wr(wdt_pkg::MODE_CONTROL_ADDR, 32'h0000_0000);
    rd_chk(wdt_pkg::MODE_CONTROL_ADDR, 32'h0000_0018, "mode bits set-only");
    wr(wdt_pkg::CLOCK_SELECT_ADDR, 32'h0000_0002);
    rd_chk(wdt_pkg::CLOCK_SELECT_ADDR, 32'h0000_0002, "main long select");
    wr(wdt_pkg::CLOCK_SELECT_ADDR, 32'h0000_00FF);
    rd_chk(wdt_pkg::CLOCK_SELECT_ADDR, 32'h0000_0006, "reserved bits read zero");
    wr(wdt_pkg::MODE_CONTROL_ADDR, 32'h0000_0080);
    await(2, SUB_L - 2 * TAP - 2, SUB_L + 4, "reset on expiry");
    check_val(32'(n_nmi + n_irq), 32'h0, "reset mode raised others");
    do_reset();
    rd_chk(wdt_pkg::MODE_CONTROL_ADDR, 32'h0, "mode cleared by reset");
  endtask

  // ------------------------------------------------------------
  // Sequence and hang guard
  // ------------------------------------------------------------
  initial begin
    t_reset_values();
    t_interval();
    t_main_select();
    t_nmi();
    n_irq = 0;
    n_nmi = 0;
    n_rst = 0;
    t_reset_mode();
    conclude();
  end

  initial begin
    repeat (98000) @(posedge clk);
    bad_count++;
    $display("unexpected at %0t: run did not complete", $time);
    conclude();
  end
endmodule // loop_detect_watchdog_test
